// [include/rxlc_pkg.sv]
package rxlc_pkg;
  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] ADR_PD = 8'h20;
  localparam logic [7:0] ADR_AGC = 8'h24;
  localparam logic [7:0] ADR_AFC = 8'h28;
  localparam logic [7:0] ADR_THR = 8'h30;
  localparam logic [7:0] ADR_DAC = 8'h38;
  localparam logic [7:0] ADR_TST = 8'h3C;
  localparam logic [7:0] ADR_STAT = 8'h40;
  // Power-down test word.
  localparam int PD_SW_OFF = 11;
  localparam int PD_RF_HALF = 0;
  localparam int PD_RATE_HIGH = 1;
  localparam logic [31:0] PD_RST = 32'h0000_0000;
  // Gain control word.
  localparam int AGC_LO_LSB = 0;
  localparam int AGC_HI_LSB = 7;
  localparam int AGC_AUTO = 18;
  localparam int AGC_LNA_LSB = 20;
  localparam int AGC_RANGE = 25;
  localparam logic [6:0] AGC_LO_DEF = 7'h1E;
  localparam logic [6:0] AGC_HI_DEF = 7'h46;
  localparam logic [4:0] LNA_GAIN_TOP = 5'h1E;
  localparam logic [4:0] LNA_GAIN_ALT = 5'h0A;
  localparam logic [31:0] AGC_RST = 32'h01E4_231E;
  // Frequency loop word.
  localparam int AFC_KP_LSB = 16;
  localparam int AFC_KI_LSB = 20;
  localparam int AFC_SPAN_LSB = 24;
  localparam logic [31:0] AFC_RST = 32'h00B4_0000;
  localparam logic [9:0] AFC_STEP_HZ = 10'h1F4;
  // Threshold, test converter and test mode words.
  localparam int THR_LOCK = 0;
  localparam int DAC_SRC = 0;
  localparam int DAC_GAIN_LSB = 8;
  localparam int DAC_OFS_LSB = 16;
  localparam logic [31:0] DAC_RST = 32'h0000_1000;
  localparam int GAIN_SHIFT = 4;
  localparam int TST_KEY_LSB = 4;
  localparam int TST_ANA_LSB = 8;
  localparam int TST_RX_LSB = 12;
  localparam int TST_TX_LSB = 15;
  localparam int TST_PULSE_LSB = 18;
  localparam int TST_LEAK_LSB = 20;
  localparam int TST_PEAK_LSB = 23;
  localparam logic [3:0] TST_TUNE_KEY = 4'h9;
  localparam logic [3:0] TST_ANA_RSSI = 4'hB;
  localparam logic [31:0] TST_RST = 32'h0000_0000;
  // Sigma-delta full-scale feedback level.
  localparam logic signed [19:0] SDM_FS = 20'sh07FFF;

  typedef struct packed {
    logic src;
    logic signed [15:0] val;
  } rxlc_smp_t;

  typedef struct packed {
    logic hready;
    logic dp_wr;
    logic [7:0] dp_adr;
    logic [31:0] hrdata;
    logic [31:0] r_pd;
    logic [31:0] r_agc;
    logic [31:0] r_afc;
    logic [31:0] r_thr;
    logic [31:0] r_dac;
    logic [31:0] r_tst;
    logic dac_en;
    rxlc_smp_t hold;
    logic signed [19:0] e1;
    logic signed [19:0] e2;
    logic sdm_bit;
    logic trx_sw;
    logic agc_auto;
    logic [6:0] agc_lo;
    logic [6:0] agc_hi;
    logic [4:0] lna;
    logic [3:0] ki;
    logic [2:0] kp;
    logic [17:0] afc_lim;
    logic freeze;
    logic tune_en;
    logic [1:0] pulse;
    logic [2:0] leak;
    logic [2:0] peak;
    logic rssi_route;
    logic cdr_bypass;
    logic cdr_run;
    logic [2:0] tx_mode;
  } rxlc_st_t;
endpackage : rxlc_pkg

// [logic/rxlc_buf.sv]
`timescale 1ns/1ps
`default_nettype none
module rxlc_buf #(
  parameter int W = 17,
  parameter int DEPTH = 2
) (
  input wire logic clock_i, // System clock.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic in_valid_i, // Word offered.
  input wire logic [W-1:0] in_data_i, // Word in.
  output logic in_ready_o, // Room for a word.
  output logic out_valid_o, // Word available.
  input wire logic out_ready_i, // Drain takes the word.
  output logic [W-1:0] out_data_o // Word out.
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } rxlc_buf_st_t;
  rxlc_buf_st_t s;
  rxlc_buf_st_t n;
  logic push;
  logic pop;

  assign push = in_valid_i && s.rdy;
  assign pop = out_ready_i && (s.cnt != '0);
  assign in_ready_o = s.rdy;
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = s.mem[s.rp];

  always_comb begin
    n = s;
    if (push) begin
      n.mem[s.wp] = in_data_i;
      n.wp = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + 1'b1;
    end
    n.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    n.rdy = (n.cnt != (AW + 1)'(DEPTH));
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.rdy <= 1'b1;
    end else begin
      s <= n;
    end
  end
endmodule : rxlc_buf
`default_nettype wire

// [logic/rxlc_ctrl.sv]
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Power-down bit 11 clear enables the internal switch; clear at reset.
// - Gain control powers up automatic with limits 30 and 70.
// - Amplifier gain 30 is granted only while range select is 0.
// - Correction span is field times 500 Hz, halved while power-down bit 0 (PD_RF_HALF) is set.
// - Threshold lock freezes detector threshold, slicer and both loops.
// - Tuning values apply only while test key nibble equals 0x9.
// - Second-order error-feedback modulator makes the one-bit stream on the pin.
// - Writing the converter word enables it; a bit picks the source.
// - Filters run at the demodulator rate, converter on recovery ticks or every cycle at the high rate.
// - Recovery rate at or above demodulator rate stops clock recovery.
// - Converter path removes a programmable offset and applies a gain.
// - Analog probe field 11 routes signal strength to the test pin.
// - Receive probe field 4, 5 or 6 bypasses clock and data recovery.
// - Transmit probe field selects test modulation.
module rxlc_ctrl #(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clock_i, // System clock, 250 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic hsel_i, // AHB slave select.
  input wire logic [31:0] haddr_i, // AHB address.
  input wire logic [1:0] htrans_i, // AHB transfer type.
  input wire logic hwrite_i, // AHB write.
  input wire logic [2:0] hsize_i, // AHB size, word only.
  input wire logic [31:0] hwdata_i, // AHB write data.
  input wire logic hready_i, // AHB bus ready.
  output logic hreadyout_o, // AHB slave ready.
  output logic hresp_o, // AHB response, always OKAY.
  output logic [31:0] hrdata_o, // AHB read data.
  input wire logic [15:0] lin_demod_i, // Linear demodulator filter output.
  input wire logic [15:0] corr_demod_i, // Correlator demodulator filter output.
  input wire logic demod_valid_i, // Demodulator sample strobe.
  output logic demod_ready_o, // Converter path can take a sample.
  input wire logic recovery_tick_i, // One pulse per recovery clock period.
  output logic sync_pin_o, // One-bit converter stream.
  output logic trx_switch_en_o, // Internal switch enabled.
  output logic agc_auto_o, // Automatic gain control.
  output logic [6:0] gain_ctrl_lower_limit_o, // Lower gain threshold.
  output logic [6:0] gain_ctrl_upper_limit_o, // Upper gain threshold.
  output logic [4:0] lna_gain_o, // Granted amplifier gain.
  output logic [3:0] freq_loop_integral_gain_o, // Integral gain.
  output logic [2:0] freq_loop_proportional_gain_o, // Proportional gain.
  output logic [17:0] freq_correction_limit_hz_o, // Correction span in Hz.
  output logic threshold_freeze_o, // Detector threshold and loops held.
  output logic tune_enable_o, // Tuning values applied.
  output logic [1:0] demod_pulse_stretch_o, // Demod_pulse_stretch.
  output logic [2:0] envelope_leak_setting_o, // Detector leak.
  output logic [2:0] envelope_peak_setting_o, // Detector peak response.
  output logic rssi_to_test_pin_o, // Signal strength on test pin.
  output logic cdr_bypass_o, // Recovery bypassed.
  output logic cdr_run_o, // Recovery running.
  output logic [2:0] transmit_probe_select_o // Transmit test modulation.
);
  rxlc_pkg::rxlc_st_t s;
  rxlc_pkg::rxlc_st_t n;
  rxlc_pkg::rxlc_smp_t in_smp;
  rxlc_pkg::rxlc_smp_t buf_smp;
  logic buf_vld;
  logic buf_rdy;
  logic step;
  logic signed [16:0] diff;
  logic signed [25:0] prod;
  logic signed [25:0] scaled;
  logic [2:0] rx_sel;

  always_comb begin
    in_smp.src = s.r_dac[rxlc_pkg::DAC_SRC];
    diff = (in_smp.src ? $signed({corr_demod_i[15], corr_demod_i})
                       : $signed({lin_demod_i[15], lin_demod_i}))
         - $signed({s.r_dac[31], s.r_dac[31:rxlc_pkg::DAC_OFS_LSB]});
    prod = diff * $signed({1'b0, s.r_dac[rxlc_pkg::DAC_GAIN_LSB +: 8]});
    scaled = prod >>> rxlc_pkg::GAIN_SHIFT;
    // Saturate so a large gain clips instead of wrapping the sign.
    if (scaled > 26'sd32767) begin
      in_smp.val = 16'sh7FFF;
    end else if (scaled < -26'sd32768) begin
      in_smp.val = 16'sh8000;
    end else begin
      in_smp.val = scaled[15:0];
    end
  end

  // The buffer absorbs the rate gap between sample strobes and modulator steps.
  rxlc_buf #(.W(17), .DEPTH(BUF_DEPTH)) u_buf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .in_valid_i(demod_valid_i && s.dac_en),
    .in_data_i(in_smp),
    .in_ready_o(buf_rdy),
    .out_valid_o(buf_vld),
    .out_ready_i(step),
    .out_data_o(buf_smp)
  );

  // Converter steps on recovery ticks, every cycle at the high rate.
  assign step = s.dac_en && (recovery_tick_i || s.r_pd[rxlc_pkg::PD_RATE_HIGH]);
  assign rx_sel = s.r_tst[rxlc_pkg::TST_RX_LSB +: 3];

  always_comb begin
    logic signed [19:0] v;
    v = '0;
    n = s;
    n.hready = 1'b1;
    if (s.dp_wr) begin
      case (s.dp_adr)
        rxlc_pkg::ADR_PD: n.r_pd = hwdata_i;
        rxlc_pkg::ADR_AGC: n.r_agc = hwdata_i;
        rxlc_pkg::ADR_AFC: n.r_afc = hwdata_i;
        rxlc_pkg::ADR_THR: n.r_thr = hwdata_i;
        rxlc_pkg::ADR_DAC: begin
          n.r_dac = hwdata_i;
          n.dac_en = 1'b1;
        end
        rxlc_pkg::ADR_TST: n.r_tst = hwdata_i;
        default: n.dac_en = s.dac_en;
      endcase
    end
    n.dp_wr = 1'b0;
    if (hsel_i && htrans_i[1] && hready_i) begin
      n.dp_wr = hwrite_i;
      n.dp_adr = haddr_i[7:0];
      // Read from the updated copy so a read right after a write sees it.
      case (haddr_i[7:0])
        rxlc_pkg::ADR_PD: n.hrdata = n.r_pd;
        rxlc_pkg::ADR_AGC: n.hrdata = n.r_agc;
        rxlc_pkg::ADR_AFC: n.hrdata = n.r_afc;
        rxlc_pkg::ADR_THR: n.hrdata = n.r_thr;
        rxlc_pkg::ADR_DAC: n.hrdata = n.r_dac;
        rxlc_pkg::ADR_TST: n.hrdata = n.r_tst;
        rxlc_pkg::ADR_STAT: n.hrdata = {24'h00_0000, s.lna[4:0], s.cdr_run,
                                        s.sdm_bit, s.dac_en};
        default: n.hrdata = 32'h0000_0000;
      endcase
    end
    if (step) begin
      if (buf_vld) begin
        n.hold = buf_smp;
      end
      v = 20'(n.hold.val) + (s.e1 <<< 1) - s.e2;
      n.sdm_bit = ~v[19];
      n.e1 = v - (v[19] ? -rxlc_pkg::SDM_FS : rxlc_pkg::SDM_FS);
      n.e2 = s.e1;
    end
    n.trx_sw = ~s.r_pd[rxlc_pkg::PD_SW_OFF];
    n.agc_auto = s.r_agc[rxlc_pkg::AGC_AUTO];
    n.agc_lo = s.r_agc[rxlc_pkg::AGC_LO_LSB +: 7];
    n.agc_hi = s.r_agc[rxlc_pkg::AGC_HI_LSB +: 7];
    n.lna = s.r_agc[rxlc_pkg::AGC_LNA_LSB +: 5];
    if (n.lna == rxlc_pkg::LNA_GAIN_TOP && s.r_agc[rxlc_pkg::AGC_RANGE]) begin
      n.lna = rxlc_pkg::LNA_GAIN_ALT;
    end
    n.ki = s.r_afc[rxlc_pkg::AFC_KI_LSB +: 4];
    n.kp = s.r_afc[rxlc_pkg::AFC_KP_LSB +: 3];
    // Span times step, halved while the PD_RF_HALF bit is set.
    // Both factors are widened first so the product is not cut to ten bits.
    n.afc_lim = (18'(s.r_afc[rxlc_pkg::AFC_SPAN_LSB +: 8]) * 18'(rxlc_pkg::AFC_STEP_HZ))
              >> s.r_pd[rxlc_pkg::PD_RF_HALF];
    n.freeze = s.r_thr[rxlc_pkg::THR_LOCK];
    n.tune_en = (s.r_tst[rxlc_pkg::TST_KEY_LSB +: 4] == rxlc_pkg::TST_TUNE_KEY);
    n.pulse = n.tune_en ? s.r_tst[rxlc_pkg::TST_PULSE_LSB +: 2] : 2'h0;
    n.leak = n.tune_en ? s.r_tst[rxlc_pkg::TST_LEAK_LSB +: 3] : 3'h0;
    n.peak = n.tune_en ? s.r_tst[rxlc_pkg::TST_PEAK_LSB +: 3] : 3'h0;
    n.rssi_route = (s.r_tst[rxlc_pkg::TST_ANA_LSB +: 4] == rxlc_pkg::TST_ANA_RSSI);
    n.cdr_bypass = (rx_sel == 3'h4) || (rx_sel == 3'h5) || (rx_sel == 3'h6);
    n.cdr_run = ~n.cdr_bypass && ~s.r_pd[rxlc_pkg::PD_RATE_HIGH];
    n.tx_mode = s.r_tst[rxlc_pkg::TST_TX_LSB +: 3];
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.hready <= 1'b1;
      s.r_pd <= rxlc_pkg::PD_RST;
      s.r_agc <= rxlc_pkg::AGC_RST;
      s.r_afc <= rxlc_pkg::AFC_RST;
      s.r_dac <= rxlc_pkg::DAC_RST;
      s.r_tst <= rxlc_pkg::TST_RST;
      s.trx_sw <= 1'b1;
      s.agc_auto <= 1'b1;
      s.agc_lo <= rxlc_pkg::AGC_LO_DEF;
      s.agc_hi <= rxlc_pkg::AGC_HI_DEF;
      s.cdr_run <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign hreadyout_o = s.hready;
  assign hresp_o = 1'b0;
  assign hrdata_o = s.hrdata;
  assign demod_ready_o = buf_rdy;
  assign sync_pin_o = s.sdm_bit;
  assign trx_switch_en_o = s.trx_sw;
  assign agc_auto_o = s.agc_auto;
  assign gain_ctrl_lower_limit_o = s.agc_lo;
  assign gain_ctrl_upper_limit_o = s.agc_hi;
  assign lna_gain_o = s.lna;
  assign freq_loop_integral_gain_o = s.ki;
  assign freq_loop_proportional_gain_o = s.kp;
  assign freq_correction_limit_hz_o = s.afc_lim;
  assign threshold_freeze_o = s.freeze;
  assign tune_enable_o = s.tune_en;
  assign demod_pulse_stretch_o = s.pulse;
  assign envelope_leak_setting_o = s.leak;
  assign envelope_peak_setting_o = s.peak;
  assign rssi_to_test_pin_o = s.rssi_route;
  assign cdr_bypass_o = s.cdr_bypass;
  assign cdr_run_o = s.cdr_run;
  assign transmit_probe_select_o = s.tx_mode;

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_dac_write;
    s.dp_wr && (s.dp_adr == rxlc_pkg::ADR_DAC);
  endsequence

  sequence s_idle_step;
    !step ##1 1'b1;
  endsequence

  a_switch_follow: assert property (
    ##1 trx_switch_en_o == !$past(s.r_pd[rxlc_pkg::PD_SW_OFF]))
    else $error("switch enable does not follow bit 11");
  a_gain_defaults: assert property (
    $past(rst_i) |-> (gain_ctrl_lower_limit_o == 7'h1E) && (gain_ctrl_upper_limit_o == 7'h46)
                     && agc_auto_o)
    else $error("gain control defaults wrong after reset");
  a_lna_gate: assert property (
    (lna_gain_o == 5'h1E) |-> !$past(s.r_agc[rxlc_pkg::AGC_RANGE]))
    else $error("top amplifier gain granted with range select set");
  a_afc_span: assert property (
    ##1 freq_correction_limit_hz_o == 18'(($past(s.r_afc[31:24]) * 500)
                                     >> $past(s.r_pd[rxlc_pkg::PD_RF_HALF])))
    else $error("correction span wrong");
  a_lock_freeze: assert property (
    s.r_thr[rxlc_pkg::THR_LOCK] ##1 s.r_thr[rxlc_pkg::THR_LOCK] |-> threshold_freeze_o)
    else $error("threshold lock not applied");
  a_tune_gate: assert property (
    (envelope_leak_setting_o != 3'h0 || envelope_peak_setting_o != 3'h0)
      |-> $past(s.r_tst[7:4]) == 4'h9)
    else $error("tuning applied without key");
  a_dac_enable: assert property (
    s_dac_write |=> s.dac_en [*3])
    else $error("converter not enabled by write");
  a_sdm_hold: assert property (
    s_idle_step |-> $stable(s.e1) && $stable(sync_pin_o))
    else $error("modulator moved without a step");
  a_sdm_sign: assert property (
    step && !buf_vld && s.hold.val == 16'sh7FFF && s.e1 == 20'sh0 && s.e2 == 20'sh0
      |=> sync_pin_o)
    else $error("modulator sign wrong");
  a_rssi_route: assert property (
    (s.r_tst[11:8] == 4'hB) |=> rssi_to_test_pin_o)
    else $error("signal strength not routed");
  a_cdr_bypass: assert property (
    (rx_sel inside {3'h4, 3'h5, 3'h6}) |=> cdr_bypass_o && !cdr_run_o)
    else $error("recovery not bypassed");
  a_rate_stop: assert property (
    s.r_pd[rxlc_pkg::PD_RATE_HIGH] |=> !cdr_run_o)
    else $error("recovery runs at high rate");
  a_tx_test: assert property (
    ##1 transmit_probe_select_o == $past(s.r_tst[17:15]))
    else $error("transmit test field not applied");
  a_path_unity: assert property (
    s.r_dac[31:8] == 24'h000010 && !s.r_dac[0] && !lin_demod_i[15]
      |-> in_smp.val == lin_demod_i)
    else $error("offset or gain path wrong");
endmodule : rxlc_ctrl
`default_nettype wire

// [verif/rx_loop_and_test_dac_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_loop_and_test_dac_control_tb;
  logic clock, rst, hwrite, send, hready, hresp, sync, trx, auto, freeze, tune, rssi, byp, crun;
  logic valid, dready, tick, half;
  logic [1:0] htrans, tmode, pulse;
  logic [31:0] haddr, hwdata, hrdata, rdv, w;
  logic [15:0] lin_v, corr_v, lin, corr;
  logic [6:0] lo, hi;
  logic [4:0] lna;
  logic [3:0] ki, ki_w;
  logic [2:0] kp_w;
  logic [2:0] kp, leak, peak, txs;
  logic [17:0] lim;
  logic [7:0] span;
  int bad_count, cmp_count, seed;

  rxlc_ctrl #(.BUF_DEPTH(2)) dut_u (.clock_i(clock), .rst_i(rst), .hsel_i(1'b1),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
    .hrdata_o(hrdata), .lin_demod_i(lin), .corr_demod_i(corr), .demod_valid_i(valid),
    .demod_ready_o(dready), .recovery_tick_i(tick), .sync_pin_o(sync),
    .trx_switch_en_o(trx), .agc_auto_o(auto), .gain_ctrl_lower_limit_o(lo),
    .gain_ctrl_upper_limit_o(hi), .lna_gain_o(lna), .freq_loop_integral_gain_o(ki),
    .freq_loop_proportional_gain_o(kp), .freq_correction_limit_hz_o(lim),
    .threshold_freeze_o(freeze), .tune_enable_o(tune), .demod_pulse_stretch_o(pulse),
    .envelope_leak_setting_o(leak), .envelope_peak_setting_o(peak),
    .rssi_to_test_pin_o(rssi), .cdr_bypass_o(byp), .cdr_run_o(crun),
    .transmit_probe_select_o(txs));

  rxlc_src src_u (.clock_i(clock), .rst_i(rst), .send_i(send), .tick_mode_i(tmode),
    .lin_i(lin_v), .corr_i(corr_v), .ready_i(dready), .valid_o(valid), .lin_o(lin),
    .corr_o(corr), .tick_o(tick));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      finish_test;
    end
  endtask : wait_ready

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rdv = hrdata;
  endtask : ahb

  task automatic settle;
    repeat (2) @(posedge clock);
    #1;
  endtask : settle

  // Share of ones expected over 400 cycles from the offset, gain and source rules.
  function automatic int exp_ones(input int s, input int o, input int g);
    return ((((s - o) * g) >>> 4) + 32767) * 400 / 65534;
  endfunction : exp_ones

  task automatic sdm(input logic src, input logic [15:0] l, input logic [15:0] c,
                     input logic [7:0] g, input logic [15:0] o, input logic [1:0] m);
    int e, ones;
    ahb(1'b1, rxlc_pkg::ADR_DAC, {o, g, 7'h00, src});
    lin_v <= l;
    corr_v <= c;
    send <= 1'b1;
    tmode <= m;
    repeat (40) @(posedge clock);
    ones = 0;
    repeat (400) begin
      @(posedge clock);
      ones += int'(sync === 1'b1);
    end
    e = exp_ones(src ? int'($signed(c)) : int'($signed(l)), int'($signed(o)), int'(g));
    chk({31'h0, ones > e - 32 && ones < e + 32}, 32'h1);
  endtask : sdm

  initial begin
    #200000;
    bad_count++;
    finish_test;
  end

  initial begin
    logic [7:0] ra [6];
    logic [31:0] rv [6];
    ra = '{rxlc_pkg::ADR_PD, rxlc_pkg::ADR_AGC, rxlc_pkg::ADR_AFC, rxlc_pkg::ADR_DAC,
           rxlc_pkg::ADR_TST, 8'h2C};
    rv = '{rxlc_pkg::PD_RST, rxlc_pkg::AGC_RST, rxlc_pkg::AFC_RST, rxlc_pkg::DAC_RST,
           rxlc_pkg::TST_RST, 32'h0};
    seed = 75205;
    rst = 1'b1;
    {htrans, hwrite, haddr, hwdata, send, tmode, lin_v, corr_v} = '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    settle;
    chk({31'h0, trx}, 32'h1);
    chk({24'h0, auto, lo}, {24'h0, 1'b1, 7'd30});
    chk({25'h0, hi}, 32'd70);
    chk({27'h0, lna}, 32'd30);
    chk({25'h0, ki, kp}, {25'h0, 4'd11, 3'd4});
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, ra[i], 32'h0);
      chk(rdv, rv[i]);
    end
    // Samples offered before the converter word is written must not move the pin.
    send <= 1'b1;
    tmode <= 2'h1;
    repeat (30) @(posedge clock);
    chk({31'h0, sync}, 32'h0);
    send <= 1'b0;
    ahb(1'b1, rxlc_pkg::ADR_PD, 32'h0000_0800);
    settle;
    chk({31'h0, trx}, 32'h0);
    ahb(1'b1, rxlc_pkg::ADR_PD, 32'h0000_0002);
    settle;
    chk({31'h0, crun}, 32'h0);
    for (int i = 0; i < 4; i++) begin
      span = 8'($random(seed));
      half = 1'(i);
      ki_w = 4'(7 + ($unsigned($random(seed)) % 9));
      kp_w = 3'($unsigned($random(seed)) % 7);
      w = {span, ki_w, 1'b0, kp_w, 16'h0};
      ahb(1'b1, rxlc_pkg::ADR_PD, {31'h0, half});
      ahb(1'b1, rxlc_pkg::ADR_AFC, w);
      ahb(1'b0, rxlc_pkg::ADR_AFC, 32'h0);
      settle;
      chk(rdv, w);
      chk({14'h0, lim}, (32'(span) * 32'd500) >> half);
      chk({25'h0, ki, kp}, {25'h0, w[23:20], w[18:16]});
    end
    for (int r = 0; r < 2; r++) begin
      w[6:0] = 7'($unsigned($random(seed)) % 40);
      // limits kept more than 30 apart
      w[13:7] = w[6:0] + 7'd31 + 7'($unsigned($random(seed)) % 50);
      w[31:14] = {6'h0, 1'(r), 5'd30, 1'b0, 1'(r), 4'h0};
      ahb(1'b1, rxlc_pkg::ADR_AGC, w);
      settle;
      chk({27'h0, lna}, r ? 32'd10 : 32'd30);
      chk({17'h0, auto, hi, lo}, {17'h0, 1'(r), w[13:0]});
    end
    for (int t = 1; t >= 0; t--) begin
      ahb(1'b1, rxlc_pkg::ADR_THR, 32'(t));
      settle;
      chk({31'h0, freeze}, 32'(t));
    end
    for (int i = 0; i < 8; i++) begin
      w = 32'($random(seed));
      w[7:4] = i[0] ? 4'h9 : 4'(i);
      w[11:8] = i[1] ? 4'hB : 4'(i);
      w[17:12] = {3'(i), 3'(i)};
      ahb(1'b1, rxlc_pkg::ADR_TST, w);
      settle;
      chk({23'h0, tune, pulse, leak, peak}, i[0] ? {23'h1, w[19:18], w[22:20], w[25:23]} : 0);
      chk({31'h0, rssi}, 32'(i[1]));
      chk({31'h0, byp}, 32'(i >= 4 && i <= 6));
      chk({29'h0, txs}, 32'(i));
    end
    ahb(1'b1, rxlc_pkg::ADR_PD, 32'h0);
    // Receiver stalls: the two-entry buffer fills and then refuses.
    tmode <= 2'h0;
    send <= 1'b1;
    ahb(1'b1, rxlc_pkg::ADR_DAC, rxlc_pkg::DAC_RST);
    repeat (8) @(posedge clock);
    chk({31'h0, dready}, 32'h0);
    ahb(1'b0, rxlc_pkg::ADR_STAT, 32'h0);
    chk(rdv & 32'hFFFF_FFFD, 32'h0000_0055);
    chk({31'h0, hresp}, 32'h0);
    tmode <= 2'h1;
    send <= 1'b0;
    repeat (8) @(posedge clock);
    chk({31'h0, dready}, 32'h1);
    sdm(1'b0, 16'h4000, 16'hC000, 8'd16, 16'h0, 2'h1);
    sdm(1'b1, 16'h4000, 16'hC000, 8'd16, 16'h0, 2'h1);
    sdm(1'b0, 16'h1000, 16'h0, 8'd16, 16'h1000, 2'h1);
    sdm(1'b0, 16'h2000, 16'h0, 8'd32, 16'h0, 2'h2);
    for (int i = 0; i < 3; i++) begin
      sdm(1'(i), 16'($signed($random(seed) % 8192)), 16'($signed($random(seed) % 8192)),
          8'($unsigned($random(seed)) % 32), 16'($signed($random(seed) % 1024)), 2'(1 + i % 2));
    end
    finish_test;
  end
endmodule : rx_loop_and_test_dac_control_tb
`default_nettype wire

// [verif/rxlc_src.sv]
`timescale 1ns/1ps
`default_nettype none
module rxlc_src (
  input wire logic clock_i, // System clock.
  input wire logic rst_i, // Reset, active high.
  input wire logic send_i, // Offer samples.
  input wire logic [1:0] tick_mode_i, // 0 still, 1 every cycle, 2 every fourth.
  input wire logic [15:0] lin_i, // Linear value to offer.
  input wire logic [15:0] corr_i, // Correlator value to offer.
  input wire logic ready_i, // Sink has room.
  output logic valid_o, // Sample offered.
  output logic [15:0] lin_o, // Linear sample.
  output logic [15:0] corr_o, // Correlator sample.
  output logic tick_o // Recovery tick.
);
  logic [1:0] cnt_q;
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      tick_o <= 1'b0;
      valid_o <= 1'b0;
      lin_o <= 16'h0000;
      corr_o <= 16'hFFFF;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      tick_o <= (tick_mode_i == 2'h1) || (tick_mode_i == 2'h2 && cnt_q == 2'h3);
      // An offered sample stands until taken; idle data toggles so stale values never match.
      if (!valid_o || ready_i) begin
        valid_o <= send_i;
        lin_o <= send_i ? lin_i : ~lin_o;
        corr_o <= send_i ? corr_i : ~corr_o;
      end
    end
  end
endmodule : rxlc_src
`default_nettype wire
